// file: src/mrd_top.sv
`timescale 1ns/100ps
`include "mrd_params.svh"

module mrd_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Configuration register port
    input  wire logic [7:0]  cfg_index,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_wr,
    output logic      [7:0]  cfg_rdata,
    // Memory cycle from CPU local bus
    input  wire logic        mem_cycle,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    input  wire logic        smm_active_level_n,
    input  wire logic        smm_cycle_strobe_n,
    input  wire logic        dram_decode_hit,
    input  wire logic        local_device_claim_n,
    // Options and multifunction pin selection
    input  wire logic        strobe_style_smm,
    input  wire logic        flush_on_entry_en,
    input  wire logic        cs_pin_en,
    input  wire logic        cs_pin_sel,
    input  wire logic        wb_pin_en,
    input  wire logic        default_l1_wb,
    // Decode results
    output logic             dram_claim,
    output logic             shadow_hit,
    output logic             local_claim,
    output logic             l1_cacheable,
    output logic             l2_cacheable,
    output logic             writeback_select_pin,
    output logic             range_cs_n,
    output logic             cache_flush_n
);

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ************************************************************
    // Pin input synchronisers
    // ************************************************************
    logic [2:0] smm_sync;
    logic [2:0] local_device_claim_n_sync;
    logic       smm_n_q;
    logic       local_device_claim_n_n_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            smm_sync  <= 3'h7;
            local_device_claim_n_sync <= 3'h7;
            smm_n_q   <= 1'b1;
            local_device_claim_n_n_q  <= 1'b1;
        end else begin
            smm_sync  <= {smm_sync[1:0], smm_active_level_n};
            local_device_claim_n_sync <= {local_device_claim_n_sync[1:0], local_device_claim_n};
            if (smm_sync[1] == smm_sync[2]) begin
                smm_n_q <= smm_sync[2];
            end
            if (local_device_claim_n_sync[1] == local_device_claim_n_sync[2]) begin
                local_device_claim_n_n_q <= local_device_claim_n_sync[2];
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [7:0] user_shadow_read_enables;
    logic [7:0] user_shadow_write_enables;
    logic [7:0] smm_shadow_enables;
    logic [7:0] range_start_mid  [2];
    logic [7:0] range_start_high [2];
    logic [7:0] range_size_attrs [2];
    logic [7:0] range_cache_attr [2];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            user_shadow_read_enables  <= `MRD_RST_REG;
            user_shadow_write_enables <= `MRD_RST_REG;
            smm_shadow_enables        <= `MRD_RST_REG;
        end else if (cfg_wr) begin
            case (cfg_index)
                `MRD_REG_USER_RD:    user_shadow_read_enables  <= cfg_wdata;
                `MRD_REG_USER_WR:    user_shadow_write_enables <= cfg_wdata;
                `MRD_REG_SMM_SHADOW: smm_shadow_enables        <= cfg_wdata;
                default: ;
            endcase
        end
    end

    // One register set per decoder
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_range_regs
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    range_start_mid[gi]  <= `MRD_RST_REG;
                    range_start_high[gi] <= `MRD_RST_REG;
                    range_size_attrs[gi] <= `MRD_RST_REG;
                    range_cache_attr[gi] <= `MRD_RST_REG;
                end else if (cfg_wr) begin
                    if (cfg_index == `MRD_REG_R0_MID + 8'(4 * gi)) begin
                        range_start_mid[gi] <= cfg_wdata;
                    end
                    if (cfg_index == `MRD_REG_R0_HIGH + 8'(4 * gi)) begin
                        range_start_high[gi] <= cfg_wdata;
                    end
                    if (cfg_index == `MRD_REG_R0_SIZE + 8'(4 * gi)) begin
                        range_size_attrs[gi] <= cfg_wdata & 8'h6F;
                    end
                    if (cfg_index == `MRD_REG_R0_CACHE + 8'(4 * gi)) begin
                        range_cache_attr[gi] <= cfg_wdata & 8'h03;
                    end
                end
            end
        end
    endgenerate

    // Read-back, registered; unmapped indices read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
        end else begin
            case (cfg_index)
                `MRD_REG_USER_RD:    cfg_rdata <= user_shadow_read_enables;
                `MRD_REG_USER_WR:    cfg_rdata <= user_shadow_write_enables;
                `MRD_REG_SMM_SHADOW: cfg_rdata <= smm_shadow_enables;
                `MRD_REG_R0_MID:     cfg_rdata <= range_start_mid[0];
                `MRD_REG_R0_HIGH:    cfg_rdata <= range_start_high[0];
                `MRD_REG_R0_SIZE:    cfg_rdata <= range_size_attrs[0];
                `MRD_REG_R0_CACHE:   cfg_rdata <= range_cache_attr[0];
                `MRD_REG_R1_MID:     cfg_rdata <= range_start_mid[1];
                `MRD_REG_R1_HIGH:    cfg_rdata <= range_start_high[1];
                `MRD_REG_R1_SIZE:    cfg_rdata <= range_size_attrs[1];
                `MRD_REG_R1_CACHE:   cfg_rdata <= range_cache_attr[1];
                default:             cfg_rdata <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Range compare
    // ************************************************************
    logic [1:0] range_hit;
    logic [1:0] hit_hole;
    logic [1:0] hit_local;
    logic [1:0] hit_nc;
    logic [1:0] hit_wt;
    logic [1:0] hit_wb;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_range_cmp
            logic [11:0] cmp_mask;
            logic [11:0] start_bits;
            logic [3:0]  size_code;
            logic [1:0]  ca;
            // Sizes above 128M are unused; clamp to the largest
            assign size_code = (range_size_attrs[gi][3:0] > `MRD_SIZE_MAX) ?
                               `MRD_SIZE_MAX : range_size_attrs[gi][3:0];
            // Address bits below the size are ignored
            assign cmp_mask   = 12'hFFF << size_code;
            assign start_bits = {range_start_high[gi][3:0], range_start_mid[gi]};
            assign range_hit[gi] = mem_cycle &&
                (mem_addr[31] == range_start_high[gi][7]) &&
                (((mem_addr[27:16] ^ start_bits) & cmp_mask) == 12'h000);
            assign ca = range_cache_attr[gi][1:0];
            // Each attribute acts on its own; all zero gives no effect
            assign hit_hole[gi]  = range_hit[gi] && range_size_attrs[gi][`MRD_HOLE_BIT];
            assign hit_local[gi] = range_hit[gi] && range_size_attrs[gi][`MRD_LOCAL_BIT];
            assign hit_nc[gi]    = range_hit[gi] && (ca == `MRD_CA_NONCACHE);
            assign hit_wt[gi]    = range_hit[gi] && (ca == `MRD_CA_WT);
            assign hit_wb[gi]    = range_hit[gi] && (ca == `MRD_CA_WB);
        end
    endgenerate

    // ************************************************************
    // Shadow selection for 768K-1M
    // ************************************************************
    logic       in_smm;
    logic       seg_c;
    logic [2:0] seg_def;
    logic [1:0] c_quarter;
    logic       shadow_rd;
    logic       shadow_wr;
    logic       in_shadow;

    // Strobe-style CPUs flag SMM per cycle, level CPUs by a steady level
    assign in_smm = strobe_style_smm ? !smm_cycle_strobe_n : !smm_n_q;
    assign in_shadow = (mem_addr[31:20] == 12'h000) && (mem_addr[19:18] == 2'h3);
    assign seg_c     = in_shadow && (mem_addr[17:16] == 2'h0);
    assign c_quarter = mem_addr[15:14];
    assign seg_def   = {in_shadow && (mem_addr[17:16] == 2'h3),
                        in_shadow && (mem_addr[17:16] == 2'h2),
                        in_shadow && (mem_addr[17:16] == 2'h1)};

    // C segments always use user bits; D/E/F pick set by SMM
    always_comb begin
        shadow_rd = 1'b0;
        shadow_wr = 1'b0;
        if (seg_c) begin
            shadow_rd = user_shadow_read_enables[c_quarter];
            shadow_wr = user_shadow_write_enables[c_quarter];
        end else begin
            for (int s = 0; s < 3; s++) begin
                if (seg_def[s]) begin
                    shadow_rd = in_smm ? smm_shadow_enables[s] :
                                user_shadow_read_enables[4 + s];
                    shadow_wr = in_smm ? smm_shadow_enables[4 + s] :
                                user_shadow_write_enables[4 + s];
                end
            end
        end
    end

    // ************************************************************
    // Cycle routing outputs
    // ************************************************************
    logic         any_hole;
    logic         any_local;
    logic         shadow_on;
    logic         next_dram;
    mrd_pkg::mrd_l1_mode_t next_l1;

    // Either decoder's hole or local bit applies
    assign any_hole  = |hit_hole;
    assign any_local = |hit_local;
    assign shadow_on = mem_write ? shadow_wr : shadow_rd;

    // Shadow space: bit decides ISA or DRAM, same DRAM in both modes
    always_comb begin
        if (in_shadow) begin
            next_dram = shadow_on && !any_hole;
        end else begin
            next_dram = dram_decode_hit && !any_hole;
        end
    end

    always_comb begin
        next_l1 = mrd_pkg::MRD_L1_DEFAULT;
        if (|hit_wt) begin
            next_l1 = mrd_pkg::MRD_L1_WT;
        end else if (|hit_wb) begin
            next_l1 = mrd_pkg::MRD_L1_WB;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dram_claim   <= 1'b0;
            shadow_hit   <= 1'b0;
            local_claim  <= 1'b0;
            l1_cacheable <= 1'b0;
            l2_cacheable <= 1'b0;
        end else begin
            dram_claim  <= mem_cycle && next_dram;
            shadow_hit  <= mem_cycle && in_shadow && shadow_on;
            // Forced claim overrides the pins; only takes the cycle from ISA
            local_claim <= mem_cycle && (any_local || !local_device_claim_n_n_q);
            // Non-cache ranges fill no lines; holes fill no L2 lines, and L1 lines only under a forced WT/WB mode
            l2_cacheable <= mem_cycle && next_dram && !(|hit_nc);
            l1_cacheable <= mem_cycle && !(|hit_nc) &&
                            (next_dram || next_l1 != mrd_pkg::MRD_L1_DEFAULT);
        end
    end

    // Write-back select pin follows the forced L1 mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            writeback_select_pin <= 1'b0;
        end else if (!wb_pin_en) begin
            writeback_select_pin <= 1'b0;
        end else begin
            case (next_l1)
                mrd_pkg::MRD_L1_WT: writeback_select_pin <= 1'b0;
                mrd_pkg::MRD_L1_WB: writeback_select_pin <= 1'b1;
                default:            writeback_select_pin <= default_l1_wb;
            endcase
        end
    end

    // Chip select needs the pin enable and a hit in the decoder picked by cs_pin_sel
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            range_cs_n <= 1'b1;
        end else begin
            range_cs_n <= !(cs_pin_en && range_hit[cs_pin_sel]);
        end
    end

    // ************************************************************
    // Flush on level-style SMM entry
    // ************************************************************
    logic       smm_n_prev;
    logic [2:0] flush_cnt;

    // Level-style entry edge only; strobe entry, exit and L2 never flushed
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            smm_n_prev    <= 1'b1;
            flush_cnt     <= 3'h0;
            cache_flush_n <= 1'b1;
        end else begin
            smm_n_prev <= smm_n_q;
            if (smm_n_prev && !smm_n_q && flush_on_entry_en && !strobe_style_smm) begin
                flush_cnt     <= `MRD_FLUSH_CLOCKS - 3'h1;
                cache_flush_n <= 1'b0;
            end else if (flush_cnt != 3'h0) begin
                flush_cnt     <= flush_cnt - 3'h1;
                cache_flush_n <= 1'b0;
            end else begin
                cache_flush_n <= 1'b1;
            end
        end
    end

endmodule

// file: common/mrd_params.svh
`ifndef MRD_PARAMS_SVH
`define MRD_PARAMS_SVH

// Register indices
`define MRD_REG_USER_RD      8'h19
`define MRD_REG_USER_WR      8'h1A
`define MRD_REG_SMM_SHADOW   8'h1C
`define MRD_REG_R0_MID       8'h30
`define MRD_REG_R0_HIGH      8'h31
`define MRD_REG_R0_SIZE      8'h32
`define MRD_REG_R0_CACHE     8'h33
`define MRD_REG_R1_MID       8'h34
`define MRD_REG_R1_HIGH      8'h35
`define MRD_REG_R1_SIZE      8'h36
`define MRD_REG_R1_CACHE     8'h37

// Reset values
`define MRD_RST_REG          8'h00

// Field positions in size/attribute register
`define MRD_HOLE_BIT         5
`define MRD_LOCAL_BIT        6
`define MRD_SIZE_MAX         4'hB

// Cache attribute codes
`define MRD_CA_DEFAULT       2'h0
`define MRD_CA_NONCACHE      2'h1
`define MRD_CA_WT            2'h2
`define MRD_CA_WB            2'h3

// Flush pulse length in clocks
`define MRD_FLUSH_CLOCKS     3'h4

`endif

// file: common/mrd_pkg.sv
package mrd_pkg;
    typedef enum logic [1:0] {
        MRD_L1_DEFAULT,
        MRD_L1_WT,
        MRD_L1_WB
    } mrd_l1_mode_t;
endpackage

// file: test/mrd_props.sv
`timescale 1ns/100ps
module mrd_props (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // Register port
    input wire logic [7:0]  cfg_index,
    input wire logic [7:0]  cfg_rdata,
    // Memory cycle and options
    input wire logic        mem_cycle,
    input wire logic [31:0] mem_addr,
    input wire logic        dram_decode_hit,
    input wire logic        strobe_style_smm,
    input wire logic        flush_on_entry_en,
    input wire logic        cs_pin_en,
    input wire logic        wb_pin_en,
    // Decode results
    input wire logic        dram_claim,
    input wire logic        writeback_select_pin,
    input wire logic        range_cs_n,
    input wire logic        cache_flush_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    logic mapped;
    assign mapped = cfg_index inside {8'h19, 8'h1A, 8'h1C, [8'h30:8'h37]};

    unmapped_reads_zero_a: assert property (!mapped |=> cfg_rdata == 8'h00)
        else $error("unmapped index read nonzero");
    size_spare_bits_a: assert property (cfg_index inside {8'h32, 8'h36}
        |=> cfg_rdata[7] == 1'h0 && cfg_rdata[4] == 1'h0)
        else $error("size register spare bits nonzero");
    cache_spare_bits_a: assert property (cfg_index inside {8'h33, 8'h37}
        |=> cfg_rdata[7:2] == 6'h00)
        else $error("cache register spare bits nonzero");
    flush_length_a: assert property ($fell(cache_flush_n)
        |-> !cache_flush_n [*4] ##1 cache_flush_n)
        else $error("flush pulse not four clocks");
    flush_cause_a: assert property ($fell(cache_flush_n)
        |-> flush_on_entry_en && !strobe_style_smm)
        else $error("flush without enabled level entry");
    wb_pin_off_a: assert property (!wb_pin_en |=> !writeback_select_pin)
        else $error("write-back pin driven while unselected");
    cs_pin_off_a: assert property (!cs_pin_en |=> range_cs_n)
        else $error("chip select while pin unselected");
    cs_on_cycle_a: assert property (!range_cs_n |-> $past(mem_cycle))
        else $error("chip select without memory cycle");
    dram_needs_decode_a: assert property (mem_cycle && !dram_decode_hit
        && mem_addr[19:18] != 2'h3 |=> !dram_claim)
        else $error("dram claim without bank decode");
endmodule

bind mrd_top mrd_props u_props (
    .clk_sys(clk_sys), .nrst(nrst), .cfg_index(cfg_index), .cfg_rdata(cfg_rdata),
    .mem_cycle(mem_cycle), .mem_addr(mem_addr), .dram_decode_hit(dram_decode_hit),
    .strobe_style_smm(strobe_style_smm), .flush_on_entry_en(flush_on_entry_en),
    .cs_pin_en(cs_pin_en), .wb_pin_en(wb_pin_en), .dram_claim(dram_claim),
    .writeback_select_pin(writeback_select_pin), .range_cs_n(range_cs_n),
    .cache_flush_n(cache_flush_n)
);

// file: test/mrd_cpu_model.sv
`timescale 1ns/100ps
module mrd_cpu_model (
    // Clock
    input  wire logic        clk_sys,
    // CPU local bus side
    output logic             mem_cycle,
    output logic             mem_write,
    output logic      [31:0] mem_addr,
    output logic             smm_active_level_n,
    output logic             smm_cycle_strobe_n
);
    initial begin
        mem_cycle          = 1'h0;
        mem_write          = 1'h0;
        mem_addr           = 32'hFFFF_FFFF;
        smm_active_level_n = 1'h1;
        smm_cycle_strobe_n = 1'h1;
    end
    task automatic drive(input logic [31:0] ad, input logic wt, input logic sm);
        mem_cycle          = 1'h1;
        mem_write          = wt;
        mem_addr           = ad;
        smm_cycle_strobe_n = !sm;
    endtask
    // Idle lines show the inverse so a stale address never passes as live
    task automatic release_bus();
        mem_cycle          = 1'h0;
        mem_write          = !mem_write;
        mem_addr           = ~mem_addr;
        smm_cycle_strobe_n = 1'h1;
    endtask
    // Level CPU holds this for many clocks, never inside a bus cycle
    task automatic set_smm(input logic lvl);
        smm_active_level_n = lvl;
    endtask
endmodule

// file: test/memory_range_decode_smm_shadow_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module memory_range_decode_smm_shadow_bench;
    logic        clk_sys = 1'h0;
    logic        nrst = 1'h0;
    logic [7:0]  cfg_index = 8'h00;
    logic [7:0]  cfg_wdata = 8'h00;
    logic        cfg_wr = 1'h0;
    logic        dram_decode_hit = 1'h0;
    logic        strobe_style_smm = 1'h0;
    logic        flush_on_entry_en = 1'h0;
    logic        cs_pin_en = 1'h0;
    logic        cs_pin_sel = 1'h0;
    logic        wb_pin_en = 1'h0;
    logic        local_device_claim_n = 1'h1;
    logic        default_l1_wb = 1'h0;
    logic [7:0]  cfg_rdata;
    logic        mem_cycle, mem_write, smm_active_level_n, smm_cycle_strobe_n;
    logic [31:0] mem_addr;
    logic        dram_claim, shadow_hit, local_claim, l1_cacheable, l2_cacheable;
    logic        writeback_select_pin, range_cs_n, cache_flush_n;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          n;
    logic [7:0]  sh [3];
    logic [7:0]  idx [12] = '{8'h19, 8'h1A, 8'h1C, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
                              8'h35, 8'h36, 8'h37, 8'h20};
    logic [31:0] a, b, m;

    always #20 clk_sys = ~clk_sys;

    mrd_top u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
        .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata), .mem_cycle(mem_cycle),
        .mem_write(mem_write), .mem_addr(mem_addr), .smm_active_level_n(smm_active_level_n),
        .smm_cycle_strobe_n(smm_cycle_strobe_n), .dram_decode_hit(dram_decode_hit),
        .local_device_claim_n(local_device_claim_n), .strobe_style_smm(strobe_style_smm),
        .flush_on_entry_en(flush_on_entry_en), .cs_pin_en(cs_pin_en), .cs_pin_sel(cs_pin_sel),
        .wb_pin_en(wb_pin_en), .default_l1_wb(default_l1_wb), .dram_claim(dram_claim),
        .shadow_hit(shadow_hit), .local_claim(local_claim), .l1_cacheable(l1_cacheable),
        .l2_cacheable(l2_cacheable), .writeback_select_pin(writeback_select_pin),
        .range_cs_n(range_cs_n), .cache_flush_n(cache_flush_n)
    );
    mrd_cpu_model u_cpu (
        .clk_sys(clk_sys), .mem_cycle(mem_cycle), .mem_write(mem_write), .mem_addr(mem_addr),
        .smm_active_level_n(smm_active_level_n), .smm_cycle_strobe_n(smm_cycle_strobe_n)
    );

    // ******
    // Helpers
    // ******
    task automatic end_sim();
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        cfg_index = i;
        cfg_wdata = d;
        cfg_wr = 1'h1;
        @(negedge clk_sys);
        cfg_wr = 1'h0;
        @(negedge clk_sys);
    endtask
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
        cfg_index = i;
        @(negedge clk_sys);
        `CHK(cfg_rdata, e)
    endtask
    task automatic mem(input logic [31:0] ad, input logic wt, input logic sm);
        u_cpu.release_bus();
        @(negedge clk_sys);
        u_cpu.drive(ad, wt, sm);
        @(negedge clk_sys);
    endtask
    task automatic prog(input logic d, input logic [31:0] st, input logic [3:0] sz,
                        input logic hole, input logic loc, input logic [1:0] ca);
        wr(d ? 8'h34 : 8'h30, st[23:16]);
        wr(d ? 8'h35 : 8'h31, st[31:24]);
        wr(d ? 8'h36 : 8'h32, {1'h0, loc, hole, 1'h0, sz});
        wr(d ? 8'h37 : 8'h33, {6'h00, ca});
    endtask
    task automatic count_low(output int c);
        c = 0;
        repeat (14) begin
            @(negedge clk_sys);
            if (cache_flush_n === 1'h0) c++;
        end
    endtask
    function automatic logic [7:0] rmask(input logic [7:0] i);
        if (i inside {8'h32, 8'h36}) return 8'h6F;
        if (i inside {8'h33, 8'h37}) return 8'h03;
        if (i inside {8'h19, 8'h1A, 8'h1C, [8'h30:8'h37]}) return 8'hFF;
        return 8'h00;
    endfunction
    // C quarters never switch set; D, E, F follow the SMM set in SMM
    function automatic logic exp_sh(input logic [31:0] ad, input logic wt, input logic sm);
        logic [7:0] u;
        int         k;
        u = wt ? sh[1] : sh[0];
        k = ad[19:16] - 4'hD;
        if (ad[19:16] == 4'hC) return u[ad[15:14]];
        if (sm) return sh[2][(wt ? 4 : 0) + k];
        return u[4 + k];
    endfunction

    // ******
    // Main sequence
    // ******
    initial begin
        void'($urandom(85));
        repeat (12) @(negedge clk_sys);
        nrst = 1'h1;
        repeat (6) @(negedge clk_sys);
        foreach (idx[i]) rd_chk(idx[i], 8'h00);
        foreach (idx[i]) begin
            b = $urandom;
            wr(idx[i], b[7:0]);
            rd_chk(idx[i], b[7:0] & rmask(idx[i]));
        end
        prog(1'h1, 32'h0, 4'h0, 1'h0, 1'h0, 2'h0);
        dram_decode_hit = 1'h1;
        for (int c = 0; c < 12; c++) begin
            b = $urandom;
            m = (32'h0001_0000 << c) - 32'h1;
            a = {4'h8, b[27:20], 1'h0, b[18:0]} & ~m;
            // No write-back cache ran before these holes, so no flush first
            prog(1'h0, a, c[3:0], 1'h1, 1'h0, 2'h0);
            mem(a | ($urandom & m), 1'h0, 1'h0);
            `CHK({dram_claim, l1_cacheable, l2_cacheable}, 3'h0)
            mem(a ^ (m + 32'h1), 1'h1, 1'h0);
            `CHK(dram_claim, 1'h1)
            mem(a ^ 32'h8000_0000, 1'h0, 1'h0);
            `CHK(dram_claim, 1'h1)
        end
        a = 32'h8122_0000;
        wb_pin_en = 1'h1;
        for (int k = 0; k < 4; k++) begin
            prog(1'h0, a, 4'h0, 1'h0, 1'h0, k[1:0]);
            dram_decode_hit = (k == 1);
            default_l1_wb = (k != 3);
            mem(a, 1'h0, 1'h0);
            `CHK({dram_claim, local_claim}, {dram_decode_hit, 1'h0})
            `CHK(writeback_select_pin, k != 2)
            if (k > 1) `CHK(l1_cacheable, 1'h1)
            if (k == 1) `CHK({l1_cacheable, l2_cacheable}, 2'h0)
        end
        // Decoder 0 covers 128K, decoder 1 only the first 64K of it; hole joins local
        prog(1'h0, a, 4'h1, 1'h1, 1'h0, 2'h0);
        prog(1'h1, a, 4'h0, 1'h0, 1'h1, 2'h0);
        cs_pin_en = 1'h1;
        dram_decode_hit = 1'h1;
        for (int k = 0; k < 4; k++) begin
            cs_pin_sel = k[0];
            mem(a + (k[1] ? 32'h0001_0000 : 32'h0), 1'h1, 1'h0);
            `CHK({dram_claim, local_claim}, {1'h0, !k[1]})
            `CHK(range_cs_n, k[0] & k[1])
        end
        prog(1'h0, 32'h8400_0000, 4'h0, 1'h0, 1'h0, 2'h0);
        mem(a, 1'h0, 1'h0);
        `CHK({dram_claim, local_claim, range_cs_n, l2_cacheable}, 4'hD)
        local_device_claim_n = 1'h0;
        repeat (5) @(negedge clk_sys);
        mem(32'h8800_0000, 1'h0, 1'h0);
        `CHK(local_claim, 1'h1)
        local_device_claim_n = 1'h1;
        repeat (5) @(negedge clk_sys);
        mem(32'h8800_0000, 1'h0, 1'h0);
        `CHK(local_claim, 1'h0)
        strobe_style_smm = 1'h1;
        for (int k = 0; k < 48; k++) begin
            if (k % 12 == 0) begin
                foreach (sh[j]) sh[j] = 8'($urandom);
                if (k == 0) sh[2] = 8'hFF;
                wr(8'h19, sh[0]);
                wr(8'h1A, sh[1]);
                wr(8'h1C, sh[2]);
            end
            b = $urandom;
            dram_decode_hit = b[22];
            a = {12'h000, 2'h3, b[17:16], b[15:0]};
            mem(a, b[20], b[21]);
            `CHK(dram_claim, exp_sh(a, b[20], b[21]))
            `CHK(shadow_hit, exp_sh(a, b[20], b[21]))
        end
        for (int k = 0; k < 3; k++) begin
            strobe_style_smm = (k == 1);
            flush_on_entry_en = (k != 2);
            @(negedge clk_sys);
            u_cpu.set_smm(1'h0);
            count_low(n);
            `CHK(n, (k == 0) ? 4 : 0)
            if (k == 0) begin
                mem(32'h000D_0000, 1'h0, 1'h0);
                `CHK(dram_claim, sh[2][0])
            end
            u_cpu.release_bus();
            u_cpu.set_smm(1'h1);
            count_low(n);
            `CHK(n, 0)
        end
        end_sim();
    end
endmodule
